/* core/ldoc_params.svh */
/*
  Constants for the four-channel linear regulator control block.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef LDOC_PARAMS_SVH
`define LDOC_PARAMS_SVH

// Channel count and code width
`define LDOC_NUM_CH 4
`define LDOC_CODE_W 4
// Index of the channel that may be pin controlled
`define LDOC_HW_CH 2
// Reset value of enable bits
`define LDOC_EN_RST 1'h0
// Reset value of voltage codes before the default load
`define LDOC_CODE_RST 4'h0
// Output millivolt width
`define LDOC_MV_W 13
// Pin filter depth
`define LDOC_SYNC_W 3

`endif

/* core/ldoc_pkg.sv */
/*
  Types for the linear regulator control block.
  Assumes ldoc_params.svh is on the include path.
*/
`include "ldoc_params.svh"

package ldoc_pkg;

  // Operating mode of one channel
  typedef enum logic [2:0] {
    LDOC_OFF_PD = 3'h1,
    LDOC_REG = 3'h2,
    LDOC_SWITCH = 3'h4
  } ldoc_mode_t;

  // Per-channel control output
  typedef struct packed {
    logic on;
    logic pull_down;
    logic load_switch;
    logic [`LDOC_CODE_W-1:0] code;
  } ldoc_ch_out_t;

  // Per-channel software write request
  typedef struct packed {
    logic wr_run_enable;
    logic wr_standby_enable;
    logic wr_run_code;
    logic wr_standby_code;
    logic enable;
    logic [`LDOC_CODE_W-1:0] code;
  } ldoc_ch_wr_t;

endpackage

/* core/ldoc_top.sv */
/*
  Control logic for four linear regulator channels: enable bits, voltage
  codes, load-switch option, pin control of channel 2.
  Assumes one 20 MHz clock, an asynchronous active-high reset standing in
  for power up, a sequencer that pulses set requests, and static OTP inputs.
*/
`timescale 1ns/1ps
`include "ldoc_params.svh"

module ldoc_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // System mode, high for standby
  input wire logic standby_mode_i,
  // Sequencer set pulses, one per channel
  input wire logic [`LDOC_NUM_CH-1:0] seq_set_i,
  // OTP settings
  input wire logic [`LDOC_NUM_CH-1:0] otp_load_switch_option_i,
  input wire logic [`LDOC_NUM_CH*`LDOC_CODE_W-1:0] otp_default_voltage_code_i,
  // Pins select hardware control of channel 2
  input wire logic hw_ctrl_i,
  input wire logic voltage_select_pin_i,
  input wire logic channel2_enable_pin_i,
  // Codes chosen by the voltage select pin
  input wire logic [`LDOC_CODE_W-1:0] vsel_low_code_i,
  input wire logic [`LDOC_CODE_W-1:0] vsel_high_code_i,
  // Software writes
  input wire ldoc_pkg::ldoc_ch_wr_t [`LDOC_NUM_CH-1:0] wr_i,
  // Stored state readback
  output logic [`LDOC_NUM_CH-1:0] channel_run_enable_o,
  output logic [`LDOC_NUM_CH-1:0] channel_standby_enable_o,
  output logic [`LDOC_NUM_CH*`LDOC_CODE_W-1:0] run_voltage_code_o,
  output logic [`LDOC_NUM_CH*`LDOC_CODE_W-1:0] standby_voltage_code_o,
  // Regulator controls
  output ldoc_pkg::ldoc_ch_out_t [`LDOC_NUM_CH-1:0] ch_o,
  output logic [`LDOC_NUM_CH*`LDOC_MV_W-1:0] ch_mv_o
);

  // Pin filter shift registers
  logic [`LDOC_SYNC_W-1:0] sync_vsel;
  logic [`LDOC_SYNC_W-1:0] sync_en2;
  logic [`LDOC_SYNC_W-1:0] sync_hw;
  // Filtered pin levels
  logic vsel_f;
  logic en2_f;
  logic hw_f;
  // First clock after reset loads OTP codes
  logic load_pending;

  // Voltage table in millivolts
  function automatic logic [`LDOC_MV_W-1:0] code_to_mv(input logic [`LDOC_CODE_W-1:0] c);
    case (c)
      4'h0: code_to_mv = 13'd1500;
      4'h1: code_to_mv = 13'd1600;
      4'h2: code_to_mv = 13'd1800;
      4'h3: code_to_mv = 13'd1850;
      4'h4: code_to_mv = 13'd2150;
      4'h5: code_to_mv = 13'd2500;
      4'h6: code_to_mv = 13'd2800;
      4'h7: code_to_mv = 13'd3000;
      4'h8: code_to_mv = 13'd3100;
      4'h9: code_to_mv = 13'd3150;
      4'hA: code_to_mv = 13'd3200;
      4'hB: code_to_mv = 13'd3300;
      4'hC: code_to_mv = 13'd3350;
      4'hD: code_to_mv = 13'd4000;
      4'hE: code_to_mv = 13'd4900;
      default: code_to_mv = 13'd5000;
    endcase
  endfunction

  // Three-stage pin synchronisers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_vsel <= 3'h0;
      sync_en2 <= 3'h0;
      sync_hw <= 3'h0;
    end else begin
      sync_vsel <= {sync_vsel[1:0], voltage_select_pin_i};
      sync_en2 <= {sync_en2[1:0], channel2_enable_pin_i};
      sync_hw <= {sync_hw[1:0], hw_ctrl_i};
    end
  end

  // Accept a pin change once stages two and three agree
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vsel_f <= 1'h0;
      en2_f <= 1'h0;
      hw_f <= 1'h0;
    end else begin
      if (sync_vsel[1] == sync_vsel[2]) begin
        vsel_f <= sync_vsel[2];
      end
      if (sync_en2[1] == sync_en2[2]) begin
        en2_f <= sync_en2[2];
      end
      if (sync_hw[1] == sync_hw[2]) begin
        hw_f <= sync_hw[2];
      end
    end
  end

  // Power-up code load flag
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      load_pending <= 1'h1;
    end else begin
      load_pending <= 1'h0;
    end
  end

  // Per-channel state and output decode
  genvar g;
  generate
    for (g = 0; g < `LDOC_NUM_CH; g = g + 1) begin : gen_ch
      // Applied enable and code for the current mode
      logic eff_en;
      logic [`LDOC_CODE_W-1:0] eff_code;
      logic is_hw;
      ldoc_pkg::ldoc_mode_t mode;

      // Enable bits: reset zero, sequencer set wins over software write
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          channel_run_enable_o[g] <= `LDOC_EN_RST;
          channel_standby_enable_o[g] <= `LDOC_EN_RST;
        end else begin
          if (seq_set_i[g]) begin
            channel_run_enable_o[g] <= 1'h1;
          end else if (wr_i[g].wr_run_enable) begin
            channel_run_enable_o[g] <= wr_i[g].enable;
          end
          if (seq_set_i[g]) begin
            channel_standby_enable_o[g] <= 1'h1;
          end else if (wr_i[g].wr_standby_enable) begin
            channel_standby_enable_o[g] <= wr_i[g].enable;
          end
        end
      end

      // Voltage codes: OTP default after power up, then software
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          run_voltage_code_o[g*4 +: 4] <= `LDOC_CODE_RST;
          standby_voltage_code_o[g*4 +: 4] <= `LDOC_CODE_RST;
        end else if (load_pending) begin
          run_voltage_code_o[g*4 +: 4] <= otp_default_voltage_code_i[g*4 +: 4];
          standby_voltage_code_o[g*4 +: 4] <= otp_default_voltage_code_i[g*4 +: 4];
        end else begin
          if (wr_i[g].wr_run_code) begin
            run_voltage_code_o[g*4 +: 4] <= wr_i[g].code;
          end
          if (wr_i[g].wr_standby_code) begin
            standby_voltage_code_o[g*4 +: 4] <= wr_i[g].code;
          end
        end
      end

      // Select the pair for the mode, or pins for channel 2
      always_comb begin
        is_hw = (g == `LDOC_HW_CH) && hw_f;
        if (is_hw) begin
          eff_en = en2_f;
          eff_code = vsel_f ? vsel_high_code_i : vsel_low_code_i;
        end else if (standby_mode_i) begin
          eff_en = channel_standby_enable_o[g];
          eff_code = standby_voltage_code_o[g*4 +: 4];
        end else begin
          eff_en = channel_run_enable_o[g];
          eff_code = run_voltage_code_o[g*4 +: 4];
        end
      end

      // Operating mode decode
      always_comb begin
        if (!eff_en) begin
          mode = ldoc_pkg::LDOC_OFF_PD;
        end else if (otp_load_switch_option_i[g]) begin
          mode = ldoc_pkg::LDOC_SWITCH;
        end else begin
          mode = ldoc_pkg::LDOC_REG;
        end
      end

      // Registered regulator controls
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          ch_o[g] <= '{on: 1'h0, pull_down: 1'h1, load_switch: 1'h0, code: 4'h0};
          ch_mv_o[g*13 +: 13] <= 13'h0;
        end else begin
          case (mode)
            ldoc_pkg::LDOC_REG: begin
              ch_o[g] <= '{on: 1'h1, pull_down: 1'h0, load_switch: 1'h0, code: eff_code};
              ch_mv_o[g*13 +: 13] <= code_to_mv(eff_code);
            end
            ldoc_pkg::LDOC_SWITCH: begin
              ch_o[g] <= '{on: 1'h1, pull_down: 1'h0, load_switch: 1'h1, code: eff_code};
              ch_mv_o[g*13 +: 13] <= 13'h0;
            end
            default: begin
              ch_o[g] <= '{on: 1'h0, pull_down: 1'h1, load_switch: 1'h0, code: eff_code};
              ch_mv_o[g*13 +: 13] <= 13'h0;
            end
          endcase
        end
      end
    end
  endgenerate

endmodule

/* tb/ldoc_checker.sv */
/* Assertions on the regulator control ports.
   Assumes a bind onto ldoc_top. */
`timescale 1ns/1ps
module ldoc_checker (
  // Clock, reset, mode
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic standby_mode_i,
  // Sequencer and OTP
  input wire logic [3:0] seq_set_i,
  input wire logic [3:0] otp_load_switch_option_i,
  input wire logic [15:0] otp_default_voltage_code_i,
  // Stored state and controls
  input wire logic [3:0] channel_run_enable_o,
  input wire logic [3:0] channel_standby_enable_o,
  input wire logic [15:0] run_voltage_code_o,
  input wire logic [15:0] standby_voltage_code_o,
  input wire ldoc_pkg::ldoc_ch_out_t [3:0] ch_o
);
  logic en; // Applied enable, channel 0
  logic ls; // Option, channel 0
  assign en = standby_mode_i ? channel_standby_enable_o[0] : channel_run_enable_o[0];
  assign ls = otp_load_switch_option_i[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_OFF: assert property (!en |=> ch_o[0].pull_down && !ch_o[0].on) else $error("not off");
  AST_RUN_OFF: assert property (!standby_mode_i && !channel_run_enable_o[0] |=> !ch_o[0].on) else $error("on");
  AST_STBY_OFF: assert property (standby_mode_i && !channel_standby_enable_o[0] |=> !ch_o[0].on) else $error("on");
  AST_REG: assert property (en && !ls |=> ch_o[0].on && !ch_o[0].load_switch) else $error("not reg");
  AST_LS: assert property (en && ls |=> ch_o[0].on && ch_o[0].load_switch) else $error("not sw");
  AST_RUN_CODE: assert property (!standby_mode_i && en |=> ch_o[0].code == $past(run_voltage_code_o[3:0]))
    else $error("run code");
  AST_STBY_CODE: assert property (standby_mode_i && en |=> ch_o[0].code == $past(standby_voltage_code_o[3:0]))
    else $error("stby code");
  AST_SEQ: assert property (seq_set_i[1] |=> channel_run_enable_o[1] && channel_standby_enable_o[1])
    else $error("set lost");
  AST_OTP: assert property ($past(rst_i) |=> run_voltage_code_o == otp_default_voltage_code_i
    && standby_voltage_code_o == otp_default_voltage_code_i) else $error("otp load");
  cover property (seq_set_i != 4'h0);
  cover property (en && ls);
  cover property (standby_mode_i && en);
endmodule

/* tb/ldoc_seq_model.sv */
/* Power-up sequencer model: one set pulse per channel slot.
   Assumes go_i is a one-cycle pulse. */
`timescale 1ns/1ps
module ldoc_seq_model (
  // Clock and start
  input wire logic clk_i,
  input wire logic go_i,
  // Channels and pacing
  input wire logic [3:0] mask_i,
  input wire logic slow_i,
  // Set pulses
  output logic [3:0] seq_set_o
);
  int st = 99; // Slot step, idle at 99
  initial seq_set_o = 4'h0;
  // Walks channels in order, slow gives four cycles a slot
  always @(posedge clk_i) begin
    seq_set_o <= 4'h0;
    if (go_i) st <= 0;
    else if (st < 99) st <= st + 1;
    if (st < 16 && st % (slow_i ? 4 : 1) == 0 && st / (slow_i ? 4 : 1) < 4)
      seq_set_o[st / (slow_i ? 4 : 1)] <= mask_i[st / (slow_i ? 4 : 1)];
  end
endmodule

/* tb/testbench.sv */
/* Self-checking bench for ldoc_top against an integer model.
   Assumes checker and sequencer model compiled first. */
`timescale 1ns/1ps
module testbench;
  logic clk_i = 0, rst_i = 1, stby = 0, go = 0, slow = 0, hw = 0, vsel = 0, pin2 = 0;
  logic [3:0] tseq = 0, mask = 0, ls = 0, lo = 0, hi = 0, seq_o, seqi, ren, sen, s;
  logic [15:0] otp = 0, rc, sc;
  logic [31:0] r = 95, x;
  logic [51:0] mv;
  ldoc_pkg::ldoc_ch_wr_t [3:0] wr = '0, w;
  ldoc_pkg::ldoc_ch_out_t [3:0] ch;
  int n_fail = 0, n_compared = 0, m_ren[4], m_sen[4], m_rc[4], m_sc[4];
  int mvt[16] = '{1500, 1600, 1800, 1850, 2150, 2500, 2800, 3000, 3100, 3150, 3200, 3300, 3350, 4000, 4900, 5000};
  always #25 clk_i = ~clk_i;
  assign seqi = seq_o | tseq;
  ldoc_seq_model seqm (.clk_i(clk_i), .go_i(go), .mask_i(mask), .slow_i(slow), .seq_set_o(seq_o));
  ldoc_top dut (.clk_i(clk_i), .rst_i(rst_i), .standby_mode_i(stby), .seq_set_i(seqi),
    .otp_load_switch_option_i(ls), .otp_default_voltage_code_i(otp), .hw_ctrl_i(hw),
    .voltage_select_pin_i(vsel), .channel2_enable_pin_i(pin2), .vsel_low_code_i(lo),
    .vsel_high_code_i(hi), .wr_i(wr), .channel_run_enable_o(ren), .channel_standby_enable_o(sen),
    .run_voltage_code_o(rc), .standby_voltage_code_o(sc), .ch_o(ch), .ch_mv_o(mv));
  // Xorshift source
  function logic [31:0] rnd();
    r = r ^ (r << 13);
    r = r ^ (r >> 17);
    r = r ^ (r << 5);
    return r;
  endfunction
  // Counted compare
  task chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Compares all channels with the model
  task check_all();
    int en, cd;
    for (int c = 0; c < 4; c++) begin
      en = stby ? m_sen[c] : m_ren[c];
      cd = stby ? m_sc[c] : m_rc[c];
      if (c == 2 && hw) begin
        en = pin2;
        cd = vsel ? hi : lo;
      end
      chk({ren[c], sen[c], rc[4*c+:4], sc[4*c+:4]}, {m_ren[c][0], m_sen[c][0], m_rc[c][3:0], m_sc[c][3:0]});
      if (en) chk(ch[c], {2'h2, ls[c], cd[3:0]});
      else chk(ch[c][6:4], 3'h2);
      chk(mv[13*c+:13], (en && !ls[c]) ? mvt[cd] : 0);
    end
  endtask
  // Verdict
  task wrap_up();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Two power-ups, each with a sequence and random traffic
  initial begin
    x = rnd();
    {otp, lo, hi} = x[23:0];
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_i) rst_i <= 1;
      ls <= {x[27:26], 1'h1, p[0]};
      repeat (3) @(posedge clk_i);
      x = rnd();
      rst_i <= 0;
      slow <= p[0];
      mask <= x[3:0];
      foreach (m_ren[c]) begin
        m_ren[c] = x[c];
        m_sen[c] = x[c];
        m_rc[c] = otp[4*c+:4];
        m_sc[c] = otp[4*c+:4];
      end
      @(posedge clk_i) go <= 1;
      @(posedge clk_i) go <= 0;
      repeat (20) @(posedge clk_i);
      #1 check_all();
      repeat (100) begin
        x = rnd();
        w = {x[31:28], rnd()};
        s = x[8:5] & {4{x[9] & x[10]}};
        @(posedge clk_i) {stby, hw, vsel, pin2} <= {x[0], x[1] & x[2], x[3], x[4]};
        tseq <= s;
        wr <= w;
        foreach (w[c]) begin
          if (w[c].wr_run_enable) m_ren[c] = w[c].enable;
          if (w[c].wr_standby_enable) m_sen[c] = w[c].enable;
          if (s[c]) {m_ren[c], m_sen[c]} = {32'h1, 32'h1};
          if (w[c].wr_run_code) m_rc[c] = w[c].code;
          if (w[c].wr_standby_code) m_sc[c] = w[c].code;
        end
        @(posedge clk_i) wr <= '0;
        tseq <= 4'h0;
        repeat (6) @(posedge clk_i);
        #1 check_all();
      end
    end
    wrap_up();
  end
  // Hang guard
  initial begin
    #(50 * 4000);
    n_fail++;
    wrap_up();
  end
endmodule
bind ldoc_top ldoc_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .standby_mode_i(standby_mode_i),
  .seq_set_i(seq_set_i), .otp_load_switch_option_i(otp_load_switch_option_i),
  .otp_default_voltage_code_i(otp_default_voltage_code_i), .channel_run_enable_o(channel_run_enable_o),
  .channel_standby_enable_o(channel_standby_enable_o), .run_voltage_code_o(run_voltage_code_o),
  .standby_voltage_code_o(standby_voltage_code_o), .ch_o(ch_o));
